// *** dv/fifo_rt_monitor.sv ***
`timescale 1ns/100ps
`include "fifo_rt_cfg.svh"
module fifo_rt_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // user to device
  input wire logic write_en_n,
  input wire logic read_en_n,
  input wire logic retransmit_pulse,
  // device to user
  input wire logic [`FIFO_DATA_W-1:0] rdata,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic almost_empty_flag,
  input wire logic almost_full_flag
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // no transfer and no rewind on the link
  sequence quiet_s;
    write_en_n && read_en_n && !retransmit_pulse;
  endsequence
  // flags leave reset showing an empty fifo
  reset_flags_a: assert property ($rose(rst_n) |-> !empty_flag_n && full_flag_n
    && !almost_empty_flag && almost_full_flag) else $error("flags wrong after reset");
  // an empty fifo is also almost empty, a full one almost full
  empty_almost_a: assert property (!empty_flag_n |-> !almost_empty_flag)
    else $error("empty without almost empty");
  full_almost_a: assert property (!full_flag_n |-> !almost_full_flag)
    else $error("full without almost full");
  // the user side keeps both enables off around a rewind
  rt_quiet_a: assert property (retransmit_pulse |-> write_en_n && read_en_n)
    else $error("transfer during rewind pulse");
  rt_recover_a: assert property ($fell(retransmit_pulse) |-> (write_en_n && read_en_n)[*5])
    else $error("transfer inside recovery");
  rt_width_a: assert property ($rose(retransmit_pulse) |-> retransmit_pulse[*3])
    else $error("rewind pulse too short");
  // flags move only when a pointer moves; eight cycles cover the rewind sync
  flag_hold_a: assert property (quiet_s[*8] |=> $stable(empty_flag_n) && $stable(full_flag_n))
    else $error("flag moved while idle");
  // a read on an empty fifo leaves the output word alone
  empty_blk_a: assert property (!empty_flag_n[*2] ##0 !read_en_n |=> $stable(rdata))
    else $error("read passed while empty");
  cover property ($rose(retransmit_pulse));
  cover property (!full_flag_n);
  cover property (!empty_flag_n && !read_en_n);
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/100ps
`include "fifo_rt_cfg.svh"
module tb_top;
  typedef logic [`FIFO_DATA_W-1:0] word_t;
  logic mclk, rst_n, clk_en, wr_req, rd_req, rt_req, depth_cfg, first_dev;
  logic rd_valid, busy, empty_n, full_n;
  word_t wr_data, rd_data, q;
  int fail_count, compares, cyc;
  fifo_rt_if link ();
  fifo_rt_device fifo_rt_device_inst (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .link(link));
  fifo_rt_user fifo_rt_user_inst (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .wr_req(wr_req), .wr_data(wr_data), .rd_req(rd_req), .rt_req(rt_req),
    .depth_cfg(depth_cfg), .first_dev(first_dev), .rd_data(rd_data), .rd_valid(rd_valid),
    .busy(busy), .empty_n(empty_n), .full_n(full_n), .link(link));
  fifo_rt_monitor fifo_rt_monitor_inst (.mclk(mclk), .rst_n(rst_n),
    .write_en_n(link.write_en_n), .read_en_n(link.read_en_n),
    .retransmit_pulse(link.retransmit_pulse), .rdata(link.rdata),
    .empty_flag_n(link.empty_flag_n), .full_flag_n(link.full_flag_n),
    .almost_empty_flag(link.almost_empty_flag), .almost_full_flag(link.almost_full_flag));
  // 50 mhz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // hang guard, far above the roughly 1500 cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  // data pattern, distinct for every slot of the fifo
  function automatic word_t w(int i);
    return word_t'(i * 5 + 3);
  endfunction
  task automatic chk(string nm, word_t seen, word_t exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
  endtask
  // mode strap is caught while reset is held
  task automatic do_reset(logic dcfg);
    rst_n <= 1'b0;
    depth_cfg <= dcfg;
    tick(16);
    rst_n <= 1'b1;
    tick(4);
  endtask
  // burst of n words, then time for the flags to settle
  task automatic wr(int n, int base);
    for (int i = 0; i < n; i++) begin
      wr_req <= 1'b1;
      wr_data <= w(base + i);
      tick(1);
    end
    wr_req <= 1'b0;
    tick(6);
  endtask
  // one read; sampled on the falling edge so the pulse is settled
  task automatic rd(word_t exp, logic ok);
    logic seen;
    seen = 1'b0;
    rd_req <= 1'b1;
    tick(1);
    rd_req <= 1'b0;
    repeat (12) begin
      @(negedge mclk);
      if (rd_valid === 1'b1 && !seen) begin
        seen = 1'b1;
        q = rd_data;
      end
    end
    chk("rd_valid", word_t'(seen), word_t'(ok));
    if (ok) chk("rd_data", q, exp);
    tick(1);
  endtask
  // rewind, then wait out pulse and recovery
  task automatic rt();
    rt_req <= 1'b1;
    tick(1);
    rt_req <= 1'b0;
    @(negedge mclk);
    chk("busy", word_t'(busy), 9'h001);
    repeat (29) @(negedge mclk);
    chk("busy", word_t'(busy), '0);
    tick(1);
  endtask
  task automatic t_replay();
    do_reset(1'b0);
    wr(5, 0);
    rd(w(0), 1'b1);
    rt();
    wr(1, 5);
    repeat (2) begin
      for (int i = 0; i < 6; i++) rd(w(i), 1'b1);
      rd(w(0), 1'b0);
      rt();
    end
    $display("test replay done");
  endtask
  task automatic t_flags();
    do_reset(1'b0);
    wr(7, 0);
    chk("almost_empty", word_t'(link.almost_empty_flag), '0);
    wr(1, 7);
    chk("almost_empty", word_t'(link.almost_empty_flag), 9'h001);
    wr(48, 8);
    chk("almost_full", word_t'(link.almost_full_flag), 9'h001);
    wr(1, 56);
    chk("almost_full", word_t'(link.almost_full_flag), '0);
    wr(8, 57); // last word hits a full fifo and is dropped
    chk("full_n", word_t'(full_n), '0);
    rd(w(0), 1'b1);
    rt();
    for (int i = 0; i < 64; i++) rd(w(i), 1'b1);
    chk("empty_n", word_t'(empty_n), '0);
    // a second full-depth rewind after the fifo ran empty
    rt();
    chk("full_n", word_t'(full_n), '0);
    rd(w(0), 1'b1);
    $display("test flags done");
  endtask
  task automatic t_depth();
    do_reset(1'b1);
    wr(3, 0);
    rd(w(0), 1'b1);
    rt();
    rd(w(1), 1'b1);
    $display("test depth done");
  endtask
  // a chained device that is not first starts with no tokens
  task automatic t_chain();
    first_dev <= 1'b0;
    do_reset(1'b1);
    wr(2, 0);
    chk("empty_n", word_t'(empty_n), '0);
    rd(w(0), 1'b0);
    first_dev <= 1'b1;
    $display("test chain done");
  endtask
  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {rst_n, wr_req, rd_req, rt_req, depth_cfg} = '0;
    wr_data = '0;
    first_dev = 1'b1;
    clk_en = 1'b1;
    t_replay();
    t_flags();
    t_depth();
    t_chain();
    end_of_test();
  end
endmodule

// *** logic/fifo_rt_cfg.svh ***
`ifndef FIFO_RT_CFG_SVH
`define FIFO_RT_CFG_SVH
// fifo geometry
`define FIFO_DATA_W 9
`define FIFO_ADDR_W 6
`define FIFO_DEPTH 64
// default almost-empty and almost-full offsets, in words
`define FIFO_DEF_EMPTY_OFS 7
`define FIFO_DEF_FULL_OFS 7
// clock period and retransmit recovery time, in ns
`define FIFO_CLK_NS 20
// least retransmit pulse width, in ns
`define FIFO_PRT_NS 60
`define FIFO_RTR_NS 90
// recovery count rounds up as a least time
`define FIFO_RTR_CYC ((`FIFO_RTR_NS + `FIFO_CLK_NS - 1) / `FIFO_CLK_NS)
`endif

// *** logic/fifo_rt_device.sv ***
`timescale 1ns/100ps
`include "fifo_rt_cfg.svh"
module fifo_rt_device #(
  parameter int addr_w = `FIFO_ADDR_W,
  parameter int depth = `FIFO_DEPTH,
  parameter int empty_ofs = `FIFO_DEF_EMPTY_OFS,
  parameter int full_ofs = `FIFO_DEF_FULL_OFS
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // link to the user side
  fifo_rt_if.fifo_end link
);
  localparam int dw = `FIFO_DATA_W;
  localparam logic [addr_w:0] depth_c = (addr_w+1)'(depth);
  localparam logic [addr_w:0] eofs_c = (addr_w+1)'(empty_ofs);
  localparam logic [addr_w:0] fofs_c = (addr_w+1)'(full_ofs);

  logic [dw-1:0] mem [depth];
  logic [addr_w-1:0] wptr_ff, rptr_ff;
  logic [addr_w:0] count_ff;
  logic [dw-1:0] rdata_ff;
  logic ef_n_ff, ff_n_ff, pae_ff, paf_ff, xo_ff;
  logic wtok_ff, rtok_ff;
  fifo_rt_pkg::mode_t mode_ff;
  logic wrapped_ff;
  logic xi_q_ff;
  logic [addr_w:0] nxt_count;
  // pin synchronisers: first stage read only by second
  logic [3:0] s1_ff, s2_ff;
  logic rt_q_ff;

  always_ff @(posedge mclk) begin
    if (clk_en) begin
      s1_ff <= {link.retransmit_pulse, link.master_reset,
                link.chain_in_or_offset_load, link.first_load_select};
      s2_ff <= s1_ff;
    end
  end

  wire rt_s = s2_ff[3];
  wire mrst = s2_ff[2] | ~rst_n;
  wire ld_s = s2_ff[1];
  wire fl_s = s2_ff[0];
  wire depth_mode = (mode_ff == fifo_rt_pkg::mode_depth);
  // retransmit acts on the rising edge of the synced pulse
  wire rt_go = rt_s & ~rt_q_ff & ~depth_mode;
  wire do_wr = ~link.write_en_n & ff_n_ff & wtok_ff;
  wire do_rd = ~link.read_en_n & ef_n_ff & rtok_ff;
  wire wr_wrap = do_wr & (wptr_ff == addr_w'(depth - 1));
  wire rd_wrap = do_rd & (rptr_ff == addr_w'(depth - 1));
  // a token comes back as one pulse on the chain input; act on its edge only
  wire xi_rise = ld_s & ~xi_q_ff;

  // mode strap caught while reset is held
  always_ff @(posedge mclk) begin
    if (clk_en && mrst) begin
      mode_ff <= ld_s ? fifo_rt_pkg::mode_depth : fifo_rt_pkg::mode_standalone;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rt_q_ff <= 1'b0;
    end else if (clk_en) begin
      rt_q_ff <= rt_s;
    end
  end

  // chain input edge detector; it follows the pin through reset as well,
  // so the first cycle after reset never shows a false edge
  always_ff @(posedge mclk) begin
    if (clk_en) begin
      xi_q_ff <= ld_s;
    end
  end

  // passing a token is a one-cycle pulse on expansion_out
  always_ff @(posedge mclk) begin
    if (mrst) begin
      xo_ff <= 1'b0;
    end else if (clk_en) begin
      xo_ff <= depth_mode & (wr_wrap | rd_wrap);
    end
  end

  // write token; outside depth mode a device always holds it, in a chain
  // only the first-load device starts with it
  always_ff @(posedge mclk) begin
    if (mrst) begin
      wtok_ff <= ~(ld_s & fl_s);
    end else if (clk_en && depth_mode) begin
      if (wr_wrap) begin
        wtok_ff <= 1'b0;
      end else if (xi_rise && !wtok_ff) begin
        wtok_ff <= 1'b1;
      end
    end
  end

  // read token; the chain pulse is shared by both passes, so a device
  // missing both tokens takes both back at once (kept simple on purpose)
  always_ff @(posedge mclk) begin
    if (mrst) begin
      rtok_ff <= ~(ld_s & fl_s);
    end else if (clk_en && depth_mode) begin
      if (rd_wrap) begin
        rtok_ff <= 1'b0;
      end else if (xi_rise && !rtok_ff) begin
        rtok_ff <= 1'b1;
      end
    end
  end

  // write port; write pointer never touched by retransmit
  always_ff @(posedge mclk) begin
    if (mrst) begin
      wptr_ff <= '0;
      wrapped_ff <= 1'b0;
    end else if (clk_en && do_wr) begin
      mem[wptr_ff] <= link.wdata;
      wptr_ff <= wr_wrap ? '0 : wptr_ff + 1'b1;
      // remembers that the last slot was filled, so a rewind with the
      // write pointer back at zero replays the whole depth, not nothing
      if (wr_wrap) begin
        wrapped_ff <= 1'b1;
      end
    end
  end

  // read port; retransmit rewinds to location zero
  always_ff @(posedge mclk) begin
    if (mrst) begin
      rptr_ff <= '0;
      rdata_ff <= '0;
    end else if (clk_en) begin
      if (rt_go) begin
        rptr_ff <= '0;
      end else if (do_rd) begin
        rdata_ff <= mem[rptr_ff];
        rptr_ff <= rd_wrap ? '0 : rptr_ff + 1'b1;
      end
    end
  end

  // next occupancy; after rewind it is the write pointer distance
  always_comb begin
    nxt_count = count_ff;
    if (rt_go) begin
      nxt_count = (wptr_ff == '0 && wrapped_ff) ? depth_c : {1'b0, wptr_ff};
    end else if (do_wr && !do_rd) begin
      nxt_count = count_ff + 1'b1;
    end else if (do_rd && !do_wr) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (mrst) begin
      count_ff <= '0;
    end else if (clk_en) begin
      count_ff <= nxt_count;
    end
  end

  // flags registered from the next occupancy, so they move on the same edge
  // as the pointers; a flag one cycle late would let a back-to-back write
  // land on a full fifo or a read run past the write pointer
  always_ff @(posedge mclk) begin
    if (mrst) begin
      ef_n_ff <= 1'b0;
      ff_n_ff <= 1'b1;
      pae_ff <= 1'b0;
      paf_ff <= 1'b1;
    end else if (clk_en) begin
      ef_n_ff <= (nxt_count != '0);
      ff_n_ff <= (nxt_count != depth_c);
      pae_ff <= (nxt_count > eofs_c);
      paf_ff <= (nxt_count < depth_c - fofs_c);
    end
  end

  assign link.rdata = rdata_ff;
  assign link.empty_flag_n = ef_n_ff;
  assign link.full_flag_n = ff_n_ff;
  assign link.almost_empty_flag = pae_ff;
  assign link.almost_full_flag = paf_ff;
  assign link.expansion_out = xo_ff;
endmodule

// *** logic/fifo_rt_if.sv ***
`timescale 1ns/100ps
`include "fifo_rt_cfg.svh"
interface fifo_rt_if;
  // write side
  logic write_en_n;
  logic [`FIFO_DATA_W-1:0] wdata;
  // read side
  logic read_en_n;
  logic [`FIFO_DATA_W-1:0] rdata;
  // control
  logic master_reset;
  logic retransmit_pulse;
  logic chain_in_or_offset_load;
  logic first_load_select;
  // status
  logic empty_flag_n;
  logic full_flag_n;
  logic almost_empty_flag;
  logic almost_full_flag;
  logic expansion_out;
  modport fifo_end (
    input write_en_n, wdata, read_en_n, master_reset, retransmit_pulse,
    input chain_in_or_offset_load, first_load_select,
    output rdata, empty_flag_n, full_flag_n, almost_empty_flag, almost_full_flag,
    output expansion_out
  );
  modport user_end (
    output write_en_n, wdata, read_en_n, master_reset, retransmit_pulse,
    output chain_in_or_offset_load, first_load_select,
    input rdata, empty_flag_n, full_flag_n, almost_empty_flag, almost_full_flag,
    input expansion_out
  );
endinterface

// *** logic/fifo_rt_pkg.sv ***
package fifo_rt_pkg;
  // configuration caught while master reset is held
  typedef enum logic [1:0] {
    mode_standalone,
    mode_depth
  } mode_t;
  // retransmit sequencing
  typedef enum logic [1:0] {
    rt_idle,
    rt_pulse,
    rt_recover
  } rt_state_t;
endpackage

// *** logic/fifo_rt_user.sv ***
`timescale 1ns/100ps
`include "fifo_rt_cfg.svh"
module fifo_rt_user (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // user requests
  input wire logic wr_req,
  input wire logic [`FIFO_DATA_W-1:0] wr_data,
  input wire logic rd_req,
  input wire logic rt_req,
  input wire logic depth_cfg,
  input wire logic first_dev,
  // user status
  output logic [`FIFO_DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic busy,
  output logic empty_n,
  output logic full_n,
  // link
  fifo_rt_if.user_end link
);
  localparam logic [3:0] pulse_c = 4'((`FIFO_PRT_NS + `FIFO_CLK_NS - 1) / `FIFO_CLK_NS + 2);
  localparam logic [3:0] rec_c = 4'(`FIFO_RTR_CYC + 2);
  fifo_rt_pkg::rt_state_t st_ff;
  logic [3:0] cnt_ff;
  logic wen_n_ff, ren_n_ff, rt_ff;
  logic [`FIFO_DATA_W-1:0] wd_ff, rd_ff;
  logic rv_ff, rd_pend_ff;

  // retransmit sequence holds enables off throughout
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= fifo_rt_pkg::rt_idle;
      cnt_ff <= 4'h0;
      rt_ff <= 1'b0;
    end else if (clk_en) begin
      case (st_ff)
        fifo_rt_pkg::rt_idle: begin
          // passed on in depth mode too: the device is the one that ignores it
          if (rt_req) begin
            st_ff <= fifo_rt_pkg::rt_pulse;
            rt_ff <= 1'b1;
            cnt_ff <= pulse_c;
          end
        end
        fifo_rt_pkg::rt_pulse: begin
          cnt_ff <= cnt_ff - 4'h1;
          if (cnt_ff == 4'h1) begin
            rt_ff <= 1'b0;
            st_ff <= fifo_rt_pkg::rt_recover;
            cnt_ff <= rec_c;
          end
        end
        fifo_rt_pkg::rt_recover: begin
          cnt_ff <= cnt_ff - 4'h1;
          if (cnt_ff == 4'h1) begin
            st_ff <= fifo_rt_pkg::rt_idle;
          end
        end
        default: st_ff <= fifo_rt_pkg::rt_idle;
      endcase
    end
  end

  wire idle = (st_ff == fifo_rt_pkg::rt_idle) && !rt_req;

  // enables are gated off while retransmitting
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wen_n_ff <= 1'b1;
      ren_n_ff <= 1'b1;
      wd_ff <= '0;
      rd_pend_ff <= 1'b0;
      rv_ff <= 1'b0;
      rd_ff <= '0;
    end else if (clk_en) begin
      wen_n_ff <= ~(wr_req & idle & link.full_flag_n);
      // reads are not gated by empty: the device blocks them itself
      ren_n_ff <= ~(rd_req & idle);
      wd_ff <= wr_data;
      // a read is taken only while the device shows data
      rd_pend_ff <= ~ren_n_ff & link.empty_flag_n;
      rv_ff <= rd_pend_ff;
      rd_ff <= link.rdata;
    end
  end

  assign link.write_en_n = wen_n_ff;
  assign link.wdata = wd_ff;
  assign link.read_en_n = ren_n_ff;
  assign link.retransmit_pulse = rt_ff;
  assign link.master_reset = ~rst_n;
  // high in reset picks depth mode; afterwards a lone device's expansion out
  // closes the ring onto its own chain input
  assign link.chain_in_or_offset_load = depth_cfg & (~rst_n | link.expansion_out);
  assign link.first_load_select = ~first_dev;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      empty_n <= 1'b0;
      full_n <= 1'b1;
    end else if (clk_en) begin
      busy <= ~idle;
      empty_n <= link.empty_flag_n;
      full_n <= link.full_flag_n;
    end
  end
  assign rd_data = rd_ff;
  assign rd_valid = rv_ff;
endmodule
